// ---- hdl/psac_pkg.sv ----
// constants for the system and auxiliary control register bank
package psac_pkg;

    // build options: which optional units exist in this configuration
    localparam logic HAS_ICACHE = 1'b1;
    localparam logic HAS_DCACHE = 1'b1;
    localparam logic HAS_MPU    = 1'b1;

    // system control bit positions
    localparam int SC_ZDT_BIT  = 19;
    localparam int SC_BRE_BIT  = 17;
    localparam int SC_CVP_BIT  = 14;
    localparam int SC_UVB_BIT  = 13;
    localparam int SC_ICE_BIT  = 12;
    localparam int SC_BPE_BIT  = 11;
    localparam int SC_AXE_BIT  = 10;
    localparam int SC_DCE_BIT  = 2;
    localparam int SC_SAL_BIT  = 1;
    localparam int SC_MPU_BIT  = 0;

    // system control: fixed-one positions, fixed positions, writable positions
    localparam logic [31:0] SC_ONES_MASK  = 32'h0005_0878;
    localparam logic [31:0] SC_FIXED_MASK = 32'h0005_8bf8;
    localparam logic [31:0] SC_WRITE_MASK = 32'h000a_7407;
    localparam logic [31:0] SC_RESET_VAL  = 32'h0000_0000;

    // auxiliary control bit positions (upper part only)
    localparam int AC_DIS_HI   = 31;
    localparam int AC_DIS_LO   = 28;
    localparam int AC_B1C_BIT  = 27;
    localparam int AC_B0C_BIT  = 26;
    localparam int AC_ITC_BIT  = 25;
    localparam int AC_SCA_BIT  = 24;
    localparam int AC_SCU_BIT  = 23;
    localparam int AC_MTL_BIT  = 22;
    localparam logic [31:0] AC_WRITE_MASK = 32'hffc0_0000;
    localparam logic [31:0] AC_RESET_VAL  = 32'h0000_0000;

    // exception vector bases; each table spans 0x1c bytes above its base
    localparam logic [31:0] VEC_LOW_BASE  = 32'h0000_0000;
    localparam logic [31:0] VEC_HIGH_BASE = 32'hffff_0000;
    localparam logic [31:0] VEC_SPAN      = 32'h0000_001c;

    // strap inputs: bit 3 vector init, bits 2..0 ram check init
    localparam int STRAP_W       = 4;
    localparam int STRAP_VEC_BIT = 3;

endpackage

// ---- hdl/ctl_access_check.sv ----
// execution-side checks steered by the control bits
`timescale 1ns/1ps
module ctl_access_check (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic zeroDivisorTrap,
    input  wire logic atomicExchangeEnable,
    input  wire logic slaveCacheRamAccessEn,
    input  wire logic slaveCacheRamUserAccess,
    input  wire logic divZeroAttempt,
    input  wire logic swapAttempt,
    input  wire logic cacheMaintAttempt,
    input  wire logic slaveRamReq,
    input  wire logic slaveRamReqPriv,
    output logic      divZeroUndef,
    output logic      swapUndef,
    output logic      swapBusLock,
    output logic      maintUndef,
    output logic      slaveRamGrant
);
    import psac_pkg::*;

    logic divZeroUndef_r, divZeroUndef_nxt;
    logic swapUndef_r,    swapUndef_nxt;
    logic swapBusLock_r,  swapBusLock_nxt;
    logic maintUndef_r,   maintUndef_nxt;
    logic slaveGrant_r,   slaveGrant_nxt;

    // next values of the per-event answers
    always_comb begin
        divZeroUndef_nxt = divZeroAttempt && zeroDivisorTrap;
        swapUndef_nxt    = swapAttempt && !atomicExchangeEnable;
        swapBusLock_nxt  = swapAttempt && atomicExchangeEnable;
        maintUndef_nxt   = cacheMaintAttempt && slaveCacheRamAccessEn;
        slaveGrant_nxt   = slaveRamReq && slaveCacheRamAccessEn
                           && (slaveRamReqPriv || slaveCacheRamUserAccess);
    end

    // answers are one-cycle pulses, one edge after the attempt
    always_ff @(posedge mclk) begin
        if (srst) begin
            divZeroUndef_r <= 1'b0;
            swapUndef_r    <= 1'b0;
            swapBusLock_r  <= 1'b0;
            maintUndef_r   <= 1'b0;
            slaveGrant_r   <= 1'b0;
        end else begin
            divZeroUndef_r <= divZeroUndef_nxt;
            swapUndef_r    <= swapUndef_nxt;
            swapBusLock_r  <= swapBusLock_nxt;
            maintUndef_r   <= maintUndef_nxt;
            slaveGrant_r   <= slaveGrant_nxt;
        end
    end

    assign divZeroUndef  = divZeroUndef_r;
    assign swapUndef     = swapUndef_r;
    assign swapBusLock   = swapBusLock_r;
    assign maintUndef    = maintUndef_r;
    assign slaveRamGrant = slaveGrant_r;

endmodule

// ---- hdl/processor_system_aux_control.sv ----
// system control and upper auxiliary control register bank
// Notes on behaviour
// - divide by zero traps as undefined when control bit 19 is set
// - control bit 17 enables the protection unit background region
// - bit 14 stored, resets zero; replacement is always random
// - bit 13 selects low or high vector table; reset from strap
// - bit 12 enables instruction cache; zero when no cache built
// - bit 11 always reads one; branch policy lives elsewhere
// - swap instructions undefined while bit 10 clear, locked otherwise
// - bit 2 enables data cache; zero when no data cache
// - bit 1 enables strict alignment checking; resets zero
// - bit 0 enables protection unit; zero when none built
// - user mode access to system control is undefined
// - auxiliary control reachable only in privileged mode
// - aux bits 31..28 switch off dual issue cases, reset zero
// - aux bits 27,26 enable bank tight memory checks, strap reset
// - aux bit 25 enables instruction tight memory check, strap reset
// - aux bit 24 gives slave cache access, disables caches, maintenance undefined
// - aux bit 23 allows unprivileged slave cache access
// - aux bit 22 set switches off fast interrupt response on multiples
`timescale 1ns/1ps
module processor_system_aux_control (
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic                        cpValid,
    input  wire logic                        cpWrite,
    input  wire logic                        cpSelAux,
    input  wire logic                        cpPrivileged,
    input  wire logic [31:0]                 cpWdata,
    output logic [31:0]                      cpRdata,
    output logic                             cpDone,
    output logic                             cpUndef,
    input  wire logic                        vectorLocationInit,
    input  wire logic [2:0]                  ramCheckInitInputs,
    input  wire logic                        divZeroAttempt,
    input  wire logic                        swapAttempt,
    input  wire logic                        cacheMaintAttempt,
    input  wire logic                        slaveRamReq,
    input  wire logic                        slaveRamReqPriv,
    output logic                             zeroDivisorTrap,
    output logic                             backdropRegionEnable,
    output logic                             cacheVictimPolicy,
    output logic                             replacementRandom,
    output logic                             upperVectorBase,
    output logic [31:0]                      vectorBase,
    output logic                             icacheEnable,
    output logic                             dcacheEnable,
    output logic                             atomicExchangeEnable,
    output logic                             strictAlignEnable,
    output logic                             mpuEnable,
    output logic [3:0]                       dualIssueOff,
    output logic                             bank1TightmemCheckEn,
    output logic                             bank0TightmemCheckEn,
    output logic                             instrTightmemCheckEn,
    output logic                             slaveCacheRamAccessEn,
    output logic                             slaveCacheRamUserAccess,
    output logic                             fastInterruptResponse,
    output logic                             divZeroUndef,
    output logic                             swapUndef,
    output logic                             swapBusLock,
    output logic                             maintUndef,
    output logic                             slaveRamGrant
);
    import psac_pkg::*;

    logic [psac_pkg::STRAP_W-1:0] strapSync1_r;
    logic [psac_pkg::STRAP_W-1:0] strapSync2_r;
    logic [31:0]                  sysCtl_r, sysCtl_nxt;
    logic [31:0]                  auxCtl_r, auxCtl_nxt;
    logic [31:0]                  rdata_r,  rdata_nxt;
    logic                         done_r,   done_nxt;
    logic                         undef_r,  undef_nxt;
    logic [31:0]                  sysView;
    logic [31:0]                  auxView;
    logic [31:0]                  sysWrMask;
    logic                         userAccess;

    // straps come from pins; two stages before anything reads them
    always_ff @(posedge mclk) begin
        strapSync1_r <= {vectorLocationInit, ramCheckInitInputs};
        strapSync2_r <= strapSync1_r;
    end

    // writable positions drop the enables of units not built
    always_comb begin
        sysWrMask = SC_WRITE_MASK;
        if (!HAS_ICACHE) sysWrMask[SC_ICE_BIT] = 1'b0;
        if (!HAS_DCACHE) sysWrMask[SC_DCE_BIT] = 1'b0;
        if (!HAS_MPU) sysWrMask[SC_MPU_BIT] = 1'b0;
    end

    // read views: stored bits plus the hard-wired ones
    always_comb begin
        sysView = (sysCtl_r & sysWrMask) | SC_ONES_MASK;
        auxView = auxCtl_r & AC_WRITE_MASK;
    end

    assign userAccess = cpValid && !cpPrivileged;

    // register update, including capture of straps while reset is held
    always_comb begin
        sysCtl_nxt = sysCtl_r;
        auxCtl_nxt = auxCtl_r;
        if (srst) begin
            sysCtl_nxt = SC_RESET_VAL;
            sysCtl_nxt[SC_UVB_BIT] = strapSync2_r[STRAP_VEC_BIT];
            auxCtl_nxt = AC_RESET_VAL;
            auxCtl_nxt[AC_B1C_BIT] = strapSync2_r[2];
            auxCtl_nxt[AC_B0C_BIT] = strapSync2_r[1];
            auxCtl_nxt[AC_ITC_BIT] = strapSync2_r[0];
        end else if (cpValid && cpWrite && cpPrivileged) begin
            if (cpSelAux) begin
                auxCtl_nxt = cpWdata & AC_WRITE_MASK;
            end else begin
                sysCtl_nxt = cpWdata & sysWrMask;
            end
        end
    end

    // access answer: read data, done and undefined pulse
    always_comb begin
        rdata_nxt = rdata_r;
        done_nxt  = cpValid;
        undef_nxt = userAccess;
        if (cpValid && !cpWrite && cpPrivileged) begin
            rdata_nxt = cpSelAux ? auxView : sysView;
        end
    end

    // registers; srst for sysCtl_r and auxCtl_r handled in the next-value logic above, the answer registers reset here
    always_ff @(posedge mclk) begin
        sysCtl_r <= sysCtl_nxt;
        auxCtl_r <= auxCtl_nxt;
        if (srst) begin
            rdata_r <= 32'h0000_0000;
            done_r  <= 1'b0;
            undef_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            done_r  <= done_nxt;
            undef_r <= undef_nxt;
        end
    end

    assign cpRdata = rdata_r;
    assign cpDone  = done_r;
    assign cpUndef = undef_r;

    // control levels seen by the rest of the core
    // trap enable
    assign zeroDivisorTrap      = sysView[SC_ZDT_BIT];
    assign backdropRegionEnable = sysView[SC_BRE_BIT];
    assign cacheVictimPolicy    = sysView[SC_CVP_BIT];
    assign replacementRandom    = 1'b1;
    assign upperVectorBase      = sysView[SC_UVB_BIT];
    assign vectorBase           = upperVectorBase ? VEC_HIGH_BASE : VEC_LOW_BASE;
    assign icacheEnable         = sysView[SC_ICE_BIT] && !auxView[AC_SCA_BIT];
    assign dcacheEnable         = sysView[SC_DCE_BIT] && !auxView[AC_SCA_BIT];
    assign atomicExchangeEnable = sysView[SC_AXE_BIT];
    assign strictAlignEnable    = sysView[SC_SAL_BIT];
    assign mpuEnable            = sysView[SC_MPU_BIT];
    assign dualIssueOff         = auxView[AC_DIS_HI:AC_DIS_LO];
    // bank checks; keeping them equal is left to software
    assign bank1TightmemCheckEn = auxView[AC_B1C_BIT];
    assign bank0TightmemCheckEn = auxView[AC_B0C_BIT];
    assign instrTightmemCheckEn = auxView[AC_ITC_BIT];
    assign slaveCacheRamAccessEn   = auxView[AC_SCA_BIT];
    assign slaveCacheRamUserAccess = auxView[AC_SCU_BIT];
    assign fastInterruptResponse   = !auxView[AC_MTL_BIT];

    // execution-side event checks
    ctl_access_check u_check (
        .mclk                    (mclk),
        .srst                    (srst),
        .zeroDivisorTrap         (zeroDivisorTrap),
        .atomicExchangeEnable    (atomicExchangeEnable),
        .slaveCacheRamAccessEn   (slaveCacheRamAccessEn),
        .slaveCacheRamUserAccess (slaveCacheRamUserAccess),
        .divZeroAttempt          (divZeroAttempt),
        .swapAttempt             (swapAttempt),
        .cacheMaintAttempt       (cacheMaintAttempt),
        .slaveRamReq             (slaveRamReq),
        .slaveRamReqPriv         (slaveRamReqPriv),
        .divZeroUndef            (divZeroUndef),
        .swapUndef               (swapUndef),
        .swapBusLock             (swapBusLock),
        .maintUndef              (maintUndef),
        .slaveRamGrant           (slaveRamGrant)
    );

    // checks on access, fixed bits, vectors, straps and events
    // user access check
    user_sys_undef_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && !cpPrivileged && !cpSelAux |=> cpUndef && cpDone && $stable(sysCtl_r))
        else $error("user access to system control not refused");
    user_aux_block_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && !cpPrivileged && cpSelAux |=> cpUndef && $stable(auxView))
        else $error("user access to auxiliary control not refused");
    fixed_bits_a: assert property (@(posedge mclk) disable iff (srst)
        (sysView & SC_FIXED_MASK) == SC_ONES_MASK)
        else $error("fixed system control bits wrong");
    vector_base_a: assert property (@(posedge mclk) disable iff (srst)
        vectorBase[15:0] == 16'h0000 && vectorBase[31:16] == {16{sysCtl_r[SC_UVB_BIT]}})
        else $error("vector base does not follow select bit");
    random_repl_a: assert property (@(posedge mclk) disable iff (srst)
        replacementRandom && (cacheVictimPolicy == sysCtl_r[SC_CVP_BIT]))
        else $error("replacement not random");
    strap_capture_a: assert property (@(posedge mclk)
        $fell(srst) |-> upperVectorBase == $past(strapSync2_r[STRAP_VEC_BIT])
            && instrTightmemCheckEn == $past(strapSync2_r[0]))
        else $error("strap not captured at reset");
    dual_issue_wr_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && cpWrite && cpPrivileged && cpSelAux
        |=> dualIssueOff == $past(cpWdata[31:28]))
        else $error("dual issue bits not written");
    align_wr_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && cpWrite && cpPrivileged && !cpSelAux
        |=> strictAlignEnable == $past(cpWdata[SC_SAL_BIT]) && cpDone && !cpUndef)
        else $error("alignment bit not written");
    maint_block_a: assert property (@(posedge mclk) disable iff (srst)
        cacheMaintAttempt && slaveCacheRamAccessEn |=> maintUndef)
        else $error("maintenance not refused during slave access");
    swap_gate_a: assert property (@(posedge mclk) disable iff (srst)
        swapAttempt |=> (swapUndef != swapBusLock)
            && (swapUndef == !$past(atomicExchangeEnable)))
        else $error("swap gating wrong");
    access_done_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid |=> cpDone && (cpUndef == !$past(cpPrivileged)))
        else $error("access not answered once");
    idle_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        !cpValid |=> !cpDone && !cpUndef)
        else $error("answer without access");
    user_rdata_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && !cpPrivileged |=> $stable(cpRdata))
        else $error("user access changed read data");
    sys_read_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && !cpWrite && cpPrivileged && !cpSelAux
        |=> (cpRdata & SC_FIXED_MASK) == SC_ONES_MASK && cpRdata[31:20] == 12'h000)
        else $error("system control readback pattern wrong");
    aux_read_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && !cpWrite && cpPrivileged && cpSelAux
        |=> cpRdata[21:0] == 22'h000000 && cpRdata[31:28] == dualIssueOff)
        else $error("auxiliary readback wrong");
    sys_reset_a: assert property (@(posedge mclk)
        $fell(srst) |-> !zeroDivisorTrap && !cacheVictimPolicy && !icacheEnable
            && !dcacheEnable && !atomicExchangeEnable && !strictAlignEnable && !mpuEnable)
        else $error("system control reset value wrong");
    aux_reset_a: assert property (@(posedge mclk)
        $fell(srst) |-> dualIssueOff == 4'h0 && !slaveCacheRamAccessEn
            && !slaveCacheRamUserAccess && fastInterruptResponse)
        else $error("auxiliary control reset value wrong");
    bank_strap_a: assert property (@(posedge mclk)
        $fell(srst) |-> bank1TightmemCheckEn == $past(strapSync2_r[2])
            && bank0TightmemCheckEn == $past(strapSync2_r[1]))
        else $error("bank check straps not captured");
    cache_off_a: assert property (@(posedge mclk) disable iff (srst)
        slaveCacheRamAccessEn |-> !icacheEnable && !dcacheEnable)
        else $error("cache enabled during slave access");
    user_grant_a: assert property (@(posedge mclk) disable iff (srst)
        slaveRamReq && !slaveRamReqPriv && !slaveCacheRamUserAccess |=> !slaveRamGrant)
        else $error("unprivileged slave access granted");
    div_trap_a: assert property (@(posedge mclk) disable iff (srst)
        divZeroAttempt |=> divZeroUndef == $past(zeroDivisorTrap))
        else $error("division trap wrong");
    fast_irq_wr_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && cpWrite && cpPrivileged && cpSelAux
        |=> fastInterruptResponse == !$past(cpWdata[AC_MTL_BIT]))
        else $error("latency control bit not written");
    region_wr_a: assert property (@(posedge mclk) disable iff (srst)
        cpValid && cpWrite && cpPrivileged && !cpSelAux
        |=> backdropRegionEnable == $past(cpWdata[SC_BRE_BIT]))
        else $error("background region bit not written");

endmodule

// ---- bench/processor_system_aux_control_tb.sv ----
// self-checking bench for the system and auxiliary control register bank
`timescale 1ns/1ps
module processor_system_aux_control_tb;

    logic        mclk, srst, cpValid, cpWrite, cpSelAux, cpPrivileged;
    logic [31:0] cpWdata, cpRdata, vectorBase;
    logic        cpDone, cpUndef, vectorLocationInit;
    logic [2:0]  ramCheckInitInputs;
    logic        divZeroAttempt, swapAttempt, cacheMaintAttempt, slaveRamReq, slaveRamReqPriv;
    logic        zeroDivisorTrap, backdropRegionEnable, cacheVictimPolicy, replacementRandom;
    logic        upperVectorBase, icacheEnable, dcacheEnable, atomicExchangeEnable;
    logic        strictAlignEnable, mpuEnable, bank1TightmemCheckEn, bank0TightmemCheckEn;
    logic        instrTightmemCheckEn, slaveCacheRamAccessEn, slaveCacheRamUserAccess;
    logic        fastInterruptResponse, divZeroUndef, swapUndef, swapBusLock, maintUndef;
    logic        slaveRamGrant;
    logic [3:0]  dualIssueOff;
    logic [4:0]  evs;
    // bench copies of the two registers and of the last privileged read
    logic [31:0] sysM, auxM, lastRd, seed, r;
    logic [32:0] cpQ[$];
    logic [4:0]  evQ[$];
    int          miscompares, samples_checked;
    bit          started;

    processor_system_aux_control dut (
        .mclk, .srst, .cpValid, .cpWrite, .cpSelAux, .cpPrivileged, .cpWdata, .cpRdata,
        .cpDone, .cpUndef, .vectorLocationInit, .ramCheckInitInputs, .divZeroAttempt,
        .swapAttempt, .cacheMaintAttempt, .slaveRamReq, .slaveRamReqPriv, .zeroDivisorTrap,
        .backdropRegionEnable, .cacheVictimPolicy, .replacementRandom, .upperVectorBase,
        .vectorBase, .icacheEnable, .dcacheEnable, .atomicExchangeEnable, .strictAlignEnable,
        .mpuEnable, .dualIssueOff, .bank1TightmemCheckEn, .bank0TightmemCheckEn,
        .instrTightmemCheckEn, .slaveCacheRamAccessEn, .slaveCacheRamUserAccess,
        .fastInterruptResponse, .divZeroUndef, .swapUndef, .swapBusLock, .maintUndef,
        .slaveRamGrant
    );

    assign evs = {divZeroUndef, swapUndef, swapBusLock, maintUndef, slaveRamGrant};

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // drops every request; a request task never lowers its own strobe, so
    // back-to-back calls never assign a strobe twice in one time step
    task automatic idle(input int n);
        {cpValid, divZeroAttempt, swapAttempt, cacheMaintAttempt, slaveRamReq} = '0;
        repeat (n) @(negedge mclk);
    endtask

    // one coprocessor access, launched at a falling edge
    task automatic cp(input logic w, input logic aux, input logic priv, input logic [31:0] wd);
        if (aux)
            wd[26] = wd[27];
        {cpValid, cpWrite, cpSelAux, cpPrivileged, cpWdata} = {1'b1, w, aux, priv, wd};
        if (priv && !w)
            lastRd = aux ? auxM : (sysM | 32'h0005_0878);
        else if (priv && aux)
            auxM = wd & 32'hffc0_0000;
        else if (priv)
            sysM = wd & 32'h000a_7407;
        cpQ.push_back({!priv, lastRd});
        @(negedge mclk);
    endtask

    // one cycle of execution-side events; expected pulses worked from the bits
    task automatic ev(input logic [4:0] v);
        {divZeroAttempt, swapAttempt, cacheMaintAttempt, slaveRamReq, slaveRamReqPriv} = v;
        evQ.push_back({v[4] & sysM[19], v[3] & !sysM[10], v[3] & sysM[10], v[2] & auxM[24],
                       v[1] & auxM[24] & (v[0] | auxM[23])});
        @(negedge mclk);
    endtask

    task automatic events(input int n);
        for (int i = 0; i < n; i++)
            ev(5'(rnd()));
        idle(1);
    endtask

    task automatic levels();
        logic [7:0]  sysExp;
        logic [33:0] cacheExp;
        logic [9:0]  auxExp;
        sysExp = {sysM[19], sysM[17], sysM[14], sysM[13], sysM[10], sysM[1], sysM[0], 1'b1};
        cacheExp = {sysM[12] & !auxM[24], sysM[2] & !auxM[24],
                    sysM[13] ? 32'hffff_0000 : 32'h0000_0000};
        auxExp = {auxM[31:23], !auxM[22]};
        check(64'({zeroDivisorTrap, backdropRegionEnable, cacheVictimPolicy, upperVectorBase,
                   atomicExchangeEnable, strictAlignEnable, mpuEnable, replacementRandom}),
              64'(sysExp));
        check(64'({icacheEnable, dcacheEnable, vectorBase}),
              64'(cacheExp));
        check(64'({dualIssueOff, bank1TightmemCheckEn, bank0TightmemCheckEn,
                   instrTightmemCheckEn, slaveCacheRamAccessEn, slaveCacheRamUserAccess,
                   fastInterruptResponse}),
              64'(auxExp));
    endtask

    // straps are sampled only while reset is held, so the model loads them here
    task automatic do_reset();
        srst = 1'b1;
        idle(12);
        srst = 1'b0;
        sysM = 32'(vectorLocationInit) << 13;
        auxM = 32'(ramCheckInitInputs) << 25;
        lastRd = '0;
    endtask

    // watcher: every access answers exactly one cycle later, events likewise
    always @(posedge mclk) begin
        #2;
        if (started) begin
            if (cpQ.size() > 0)
                check(64'({cpDone, cpUndef, cpRdata}), 64'({1'b1, cpQ.pop_front()}));
            else
                check(64'(cpDone), 64'h0);
            if (evQ.size() > 0)
                check(64'(evs), 64'(evQ.pop_front()));
            else
                check(64'(evs), 64'h0);
        end
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        stop_test();
    end

    initial begin
        seed = 32'h0000_0055;
        {cpWrite, cpSelAux, cpPrivileged, cpWdata, slaveRamReqPriv} = '0;
        {vectorLocationInit, ramCheckInitInputs} = 4'(rnd()) | 4'b1000;
        do_reset();
        started = 1'b1;
        levels();
        events(8);
        cp(1'b0, 1'b0, 1'b1, 32'h0);
        cp(1'b0, 1'b1, 1'b1, 32'h0);
        cp(1'b1, 1'b0, 1'b1, 32'hffff_ffff);
        cp(1'b0, 1'b0, 1'b1, 32'h0);
        idle(1);
        levels();
        // user mode attempts must leave registers and read data untouched
        cp(1'b1, 1'b0, 1'b0, 32'h0);
        cp(1'b1, 1'b1, 1'b0, 32'hffff_ffff);
        cp(1'b0, 1'b1, 1'b0, 32'h0);
        cp(1'b0, 1'b0, 1'b1, 32'h0);
        cp(1'b1, 1'b0, 1'b1, lastRd ^ 32'h0008_2403);
        idle(1);
        levels();
        cp(1'b1, 1'b1, 1'b1, 32'hffff_ffff);
        cp(1'b0, 1'b1, 1'b1, 32'h0);
        idle(1);
        levels();
        events(16);
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            cp(r[0], r[1], r[2] | r[3], rnd());
            if (r[4]) begin
                idle(1);
                levels();
                events(3);
            end
        end
        // second reset with other straps; later strap moves must not leak in
        {vectorLocationInit, ramCheckInitInputs} = 4'b0010;
        do_reset();
        levels();
        {vectorLocationInit, ramCheckInitInputs} = 4'b1101;
        idle(6);
        levels();
        cp(1'b0, 1'b0, 1'b1, 32'h0);
        cp(1'b0, 1'b1, 1'b1, 32'h0);
        idle(3);
        stop_test();
    end

endmodule
